// [core/adc_control_registers.sv]
// converter control special function registers
//
// Overview of operation
// [R1] gain calibration bytes written by software replace active calibration at once
// [R2] upper selector nibble picks positive input, common or temperature sensor
// [R3] lower selector nibble picks negative input with the same coding
// [R4] temperature sensor is measured only when whole selector holds all ones
// [R5] baud double bit doubles second serial port rate, reset clear
// [R6] aux enable gates the shared auxiliary interrupt, reset disabled
// [R7] aux flag set by hardware or software write; software clears it
// [R8] watchdog flag set by event or software; interrupt only without reset action
// [R9] result is three bytes; reading low byte clears converter interrupt
// [R10] burnout bit turns on opposing current sources, default off
// [R11] internal reference enable, default on
// [R12] reference level select: clear 1.25V, set 2.5V default
// [R13] input buffer enable, default bypassed
// [R14] gain select field gives gain of two to the field value
// [R15] polarity bit: clear bipolar, set unipolar, result and summation
// [R16] bipolar spans 800000h..7FFFFFh, unipolar 000000h..FFFFFFh half step
// [R17] two-bit field selects auto, fast, sinc2 or sinc3 filter
// [R18] writing codes 1..5 starts a calibration; field reads back zero
// [R19] summation sign-extends when bipolar coding is selected
// [R20] reserved calibration codes start nothing
// [R21] fixed bits of enable and flag register read constant
`timescale 1ns/1ps
module adc_control_registers (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  output logic SFR_HIT,
  input wire logic [7:0] GAIN_CAL_LOW,
  output logic [23:0] GAIN_CAL,
  output logic [3:0] POSITIVE_INPUT_FIELD,
  output logic [3:0] NEGATIVE_INPUT_FIELD,
  output logic TEMP_SENSOR_SEL,
  output logic SECOND_PORT_BAUD_DOUBLE,
  input wire logic AUX_EVENT,
  output logic AUX_INT_REQ,
  input wire logic WDT_EVENT,
  input wire logic WDT_INT_EN,
  input wire logic WDT_RESET_ACTION,
  output logic WDT_INT_REQ,
  input wire logic CONV_DONE,
  input wire logic signed [24:0] CONV_SAMPLE,
  output logic CONV_IRQ,
  output logic BURNOUT_DETECT,
  output logic INTERNAL_REFERENCE_ENABLE,
  output logic REFERENCE_LEVEL_SELECT,
  output logic INPUT_BUFFER_ENABLE,
  output logic [2:0] GAIN_SELECT,
  output logic [7:0] GAIN_FACTOR,
  output logic CODING_POLARITY,
  output logic SUM_SIGN_EXTEND,
  output logic [1:0] SETTLING_FILTER_MODE,
  output logic CAL_START,
  output logic [2:0] CALIBRATION_COMMAND
);
  logic [7:0] gain_mid_q;
  logic [7:0] gain_high_q;
  logic [7:0] input_select_q;
  logic [7:0] iflags_q;
  logic [7:0] iflags_d;
  logic [7:0] front_q;
  logic [7:0] mode_q;
  logic [2:0] cal_cmd_q;
  logic cal_start_q;
  logic conv_irq_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [23:0] result;
  logic result_new;
  logic hit;
  logic wr_iflags;
  logic wr_mode;
  logic rd_result_low;
  logic cal_valid;

  always_comb begin
    hit = (SFR_ADDR >= adc_ctrl_pkg::OFS_GAIN_CAL_MIDDLE) && (SFR_ADDR <= adc_ctrl_pkg::OFS_MODE_CTRL);
  end

  assign SFR_HIT = hit;
  assign wr_iflags = SFR_WR && (SFR_ADDR == adc_ctrl_pkg::OFS_INT_EN_FLAGS);
  assign wr_mode = SFR_WR && (SFR_ADDR == adc_ctrl_pkg::OFS_MODE_CTRL);
  assign rd_result_low = SFR_RD && (SFR_ADDR == adc_ctrl_pkg::OFS_RESULT_LOW);
  // reserved codes 6 and 7, and code 0, start nothing
  assign cal_valid = (SFR_WDATA[2:0] != adc_ctrl_pkg::CAL_NONE)
    && (SFR_WDATA[2:0] <= adc_ctrl_pkg::CAL_SYS_GAIN); // R20

  // gain calibration bytes take effect on the write edge
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      gain_mid_q <= adc_ctrl_pkg::RST_GAIN_CAL_MIDDLE;
      gain_high_q <= adc_ctrl_pkg::RST_GAIN_CAL_HIGH;
    end else if (SFR_WR) begin
      if (SFR_ADDR == adc_ctrl_pkg::OFS_GAIN_CAL_MIDDLE) begin
        gain_mid_q <= SFR_WDATA; // R1
      end
      if (SFR_ADDR == adc_ctrl_pkg::OFS_GAIN_CAL_HIGH) begin
        gain_high_q <= SFR_WDATA; // R1
      end
    end
  end

  assign GAIN_CAL = {gain_high_q, gain_mid_q, GAIN_CAL_LOW}; // R1

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      input_select_q <= adc_ctrl_pkg::RST_INPUT_SELECT;
    end else if (SFR_WR && (SFR_ADDR == adc_ctrl_pkg::OFS_INPUT_SELECT)) begin
      input_select_q <= SFR_WDATA;
    end
  end

  assign POSITIVE_INPUT_FIELD = input_select_q[7:4]; // R2
  assign NEGATIVE_INPUT_FIELD = input_select_q[3:0]; // R3
  // one-sided sensor codes are not a valid setup, so the sensor stays off
  assign TEMP_SENSOR_SEL = (input_select_q == adc_ctrl_pkg::SEL_TEMP_BOTH); // R4

  // hardware set wins over a software clear in the same cycle
  always_comb begin
    iflags_d = iflags_q;
    if (wr_iflags) begin
      iflags_d = SFR_WDATA & adc_ctrl_pkg::INT_EN_FLAGS_RW_MASK; // R5 R6 R7 R8
    end
    if (AUX_EVENT) begin
      iflags_d[adc_ctrl_pkg::BIT_AUX_FLAG] = 1'b1; // R7
    end
    if (WDT_EVENT) begin
      iflags_d[adc_ctrl_pkg::BIT_WDT_FLAG] = 1'b1; // R8
    end
    iflags_d = iflags_d | adc_ctrl_pkg::INT_EN_FLAGS_FIXED; // R21
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      iflags_q <= adc_ctrl_pkg::RST_INT_EN_FLAGS;
    end else begin
      iflags_q <= iflags_d;
    end
  end

  assign SECOND_PORT_BAUD_DOUBLE = iflags_q[adc_ctrl_pkg::BIT_BAUD_DOUBLE]; // R5
  assign AUX_INT_REQ = iflags_q[adc_ctrl_pkg::BIT_AUX_ENABLE]
    && iflags_q[adc_ctrl_pkg::BIT_AUX_FLAG]; // R6 R7
  // with the reset action armed the watchdog never interrupts
  assign WDT_INT_REQ = WDT_INT_EN && !WDT_RESET_ACTION
    && iflags_q[adc_ctrl_pkg::BIT_WDT_FLAG]; // R8

  result_hold u_result (
    .clk(CORE_CLK),
    .nrst(NRST),
    .sample_valid(CONV_DONE),
    .sample(CONV_SAMPLE),
    .unipolar(mode_q[adc_ctrl_pkg::BIT_POLARITY]),
    .result_q(result),
    .result_new_q(result_new)
  );

  // a new result in the clearing cycle keeps the request up
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      conv_irq_q <= 1'b0;
    end else if (result_new) begin
      conv_irq_q <= 1'b1;
    end else if (rd_result_low) begin
      conv_irq_q <= 1'b0; // R9
    end
  end

  assign CONV_IRQ = conv_irq_q;

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      front_q <= adc_ctrl_pkg::RST_FRONT_CTRL;
    end else if (SFR_WR && (SFR_ADDR == adc_ctrl_pkg::OFS_FRONT_CTRL)) begin
      front_q <= SFR_WDATA & adc_ctrl_pkg::FRONT_CTRL_RW_MASK;
    end
  end

  assign BURNOUT_DETECT = front_q[adc_ctrl_pkg::BIT_BURNOUT]; // R10
  assign INTERNAL_REFERENCE_ENABLE = front_q[adc_ctrl_pkg::BIT_VREF_EN]; // R11
  assign REFERENCE_LEVEL_SELECT = front_q[adc_ctrl_pkg::BIT_VREF_HIGH]; // R12
  assign INPUT_BUFFER_ENABLE = front_q[adc_ctrl_pkg::BIT_BUFFER_EN]; // R13
  assign GAIN_SELECT = front_q[2:0];
  assign GAIN_FACTOR = 8'h01 << front_q[2:0]; // R14

  // polarity and filter bits; calibration field is kept apart
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      mode_q <= adc_ctrl_pkg::RST_MODE_CTRL;
    end else if (wr_mode) begin
      mode_q <= SFR_WDATA & adc_ctrl_pkg::MODE_CTRL_RW_MASK; // R15 R17
    end
  end

  assign CODING_POLARITY = mode_q[adc_ctrl_pkg::BIT_POLARITY]; // R15
  assign SUM_SIGN_EXTEND = !mode_q[adc_ctrl_pkg::BIT_POLARITY]; // R19
  assign SETTLING_FILTER_MODE = mode_q[adc_ctrl_pkg::POS_FILTER +: 2]; // R17

  // the last started command stays visible to the converter
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      cal_cmd_q <= adc_ctrl_pkg::CAL_NONE;
      cal_start_q <= 1'b0;
    end else begin
      cal_start_q <= wr_mode && cal_valid; // R18 R20
      if (wr_mode && cal_valid) begin
        cal_cmd_q <= SFR_WDATA[2:0]; // R18
      end
    end
  end

  assign CAL_START = cal_start_q;
  assign CALIBRATION_COMMAND = cal_cmd_q;

  always_comb begin
    case (SFR_ADDR)
      adc_ctrl_pkg::OFS_GAIN_CAL_MIDDLE: rdata_d = gain_mid_q;
      adc_ctrl_pkg::OFS_GAIN_CAL_HIGH: rdata_d = gain_high_q;
      adc_ctrl_pkg::OFS_INPUT_SELECT: rdata_d = input_select_q;
      adc_ctrl_pkg::OFS_INT_EN_FLAGS: rdata_d = iflags_q; // R21
      adc_ctrl_pkg::OFS_RESULT_LOW: rdata_d = result[7:0]; // R9
      adc_ctrl_pkg::OFS_RESULT_MIDDLE: rdata_d = result[15:8]; // R9
      adc_ctrl_pkg::OFS_RESULT_HIGH: rdata_d = result[23:16]; // R9
      adc_ctrl_pkg::OFS_FRONT_CTRL: rdata_d = front_q;
      adc_ctrl_pkg::OFS_MODE_CTRL: rdata_d = mode_q | {5'h00, adc_ctrl_pkg::CAL_READBACK}; // R18
      default: rdata_d = 8'h00;
    endcase
  end

  // read data held until the next read strobe
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      rdata_q <= 8'h00;
    end else if (SFR_RD) begin
      rdata_q <= rdata_d;
    end
  end

  assign SFR_RDATA = rdata_q;

  sequence s_write_mid;
    SFR_WR && (SFR_ADDR == adc_ctrl_pkg::OFS_GAIN_CAL_MIDDLE);
  endsequence

  a_gain_cal_write: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R1
    s_write_mid |=> GAIN_CAL[15:8] == $past(SFR_WDATA))
    else $error("gain calibration middle byte not applied");

  a_positive_select: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R2
    SFR_WR && (SFR_ADDR == adc_ctrl_pkg::OFS_INPUT_SELECT)
    |=> POSITIVE_INPUT_FIELD == $past(SFR_WDATA[7:4]))
    else $error("positive selector not updated");

  a_negative_select: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R3
    SFR_WR && (SFR_ADDR == adc_ctrl_pkg::OFS_INPUT_SELECT)
    |=> NEGATIVE_INPUT_FIELD == $past(SFR_WDATA[3:0]))
    else $error("negative selector not updated");

  a_temp_sensor_both: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R4
    TEMP_SENSOR_SEL |-> POSITIVE_INPUT_FIELD == adc_ctrl_pkg::SEL_TEMP_SENSOR
    && NEGATIVE_INPUT_FIELD == adc_ctrl_pkg::SEL_TEMP_SENSOR)
    else $error("temperature sensor selected on one side only");

  a_aux_gate: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R6
    !iflags_q[adc_ctrl_pkg::BIT_AUX_ENABLE] |-> !AUX_INT_REQ)
    else $error("aux interrupt raised while disabled");

  sequence s_aux_armed;
    AUX_EVENT && iflags_q[adc_ctrl_pkg::BIT_AUX_ENABLE] && !wr_iflags;
  endsequence

  a_aux_set_wins: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R7
    AUX_EVENT |=> iflags_q[adc_ctrl_pkg::BIT_AUX_FLAG])
    else $error("aux event lost");

  a_aux_request: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R7
    s_aux_armed |=> AUX_INT_REQ)
    else $error("aux request missing after event");

  a_wdt_reset_gate: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R8
    WDT_RESET_ACTION |-> !WDT_INT_REQ)
    else $error("watchdog interrupt while reset action armed");

  sequence s_result_read;
    conv_irq_q && rd_result_low && !result_new;
  endsequence

  a_result_clear: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R9
    s_result_read |=> !CONV_IRQ)
    else $error("reading low result byte did not clear request");

  a_result_raise: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R9
    CONV_DONE |-> ##2 CONV_IRQ)
    else $error("conversion done did not raise request");

  a_gain_factor: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R14
    GAIN_SELECT == 3'h7 |-> GAIN_FACTOR == 8'h80)
    else $error("gain factor wrong for top code");

  a_cal_reserved: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R20
    wr_mode && (SFR_WDATA[2:0] > adc_ctrl_pkg::CAL_SYS_GAIN)
    |=> !CAL_START && $stable(CALIBRATION_COMMAND))
    else $error("reserved calibration code started a calibration");

  // back to back starts are legal, so the pulse end is checked from its cause
  a_cal_start: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R18
    wr_mode && cal_valid |=> CAL_START && CALIBRATION_COMMAND == $past(SFR_WDATA[2:0]))
    else $error("calibration start pulse wrong");

  a_cal_pulse: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R18 R20
    CAL_START |-> $past(wr_mode && cal_valid))
    else $error("calibration start without a valid command write");

  a_baud_write: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R5
    wr_iflags |=> SECOND_PORT_BAUD_DOUBLE == $past(SFR_WDATA[adc_ctrl_pkg::BIT_BAUD_DOUBLE]))
    else $error("baud double bit not written");

  a_aux_sw_write: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R7
    wr_iflags && !AUX_EVENT |=> iflags_q[adc_ctrl_pkg::BIT_AUX_FLAG] == $past(SFR_WDATA[adc_ctrl_pkg::BIT_AUX_FLAG]))
    else $error("aux flag not set or cleared by software");

  a_wdt_event_set: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R8
    WDT_EVENT |=> iflags_q[adc_ctrl_pkg::BIT_WDT_FLAG])
    else $error("watchdog event lost");

  a_front_write: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R10 R11 R12 R13
    SFR_WR && (SFR_ADDR == adc_ctrl_pkg::OFS_FRONT_CTRL)
    |=> BURNOUT_DETECT == $past(SFR_WDATA[adc_ctrl_pkg::BIT_BURNOUT])
    && INTERNAL_REFERENCE_ENABLE == $past(SFR_WDATA[adc_ctrl_pkg::BIT_VREF_EN])
    && REFERENCE_LEVEL_SELECT == $past(SFR_WDATA[adc_ctrl_pkg::BIT_VREF_HIGH])
    && INPUT_BUFFER_ENABLE == $past(SFR_WDATA[adc_ctrl_pkg::BIT_BUFFER_EN]))
    else $error("front control bits not written");

  a_filter_write: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R15 R17
    wr_mode |=> SETTLING_FILTER_MODE == $past(SFR_WDATA[adc_ctrl_pkg::POS_FILTER +: 2])
    && CODING_POLARITY == $past(SFR_WDATA[adc_ctrl_pkg::BIT_POLARITY]))
    else $error("polarity or filter mode not written");

  a_cal_readback: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R18
    SFR_RD && (SFR_ADDR == adc_ctrl_pkg::OFS_MODE_CTRL) |=> SFR_RDATA[2:0] == 3'h0)
    else $error("calibration field read back non-zero");

  a_fixed_bits: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R21
    SFR_RD && (SFR_ADDR == adc_ctrl_pkg::OFS_INT_EN_FLAGS)
    |=> SFR_RDATA[6] && SFR_RDATA[2:0] == 3'h0)
    else $error("fixed flag register bits read wrong");

  a_sign_extend: assert property (@(posedge CORE_CLK) disable iff (!NRST) // R19
    SUM_SIGN_EXTEND != CODING_POLARITY)
    else $error("sign extension does not follow polarity");
endmodule

// [core/adc_ctrl_pkg.sv]
// constants for the converter control register set
package adc_ctrl_pkg;
  // register offsets on the special function register bus
  localparam logic [7:0] OFS_GAIN_CAL_MIDDLE = 8'hd5;
  localparam logic [7:0] OFS_GAIN_CAL_HIGH = 8'hd6;
  localparam logic [7:0] OFS_INPUT_SELECT = 8'hd7;
  localparam logic [7:0] OFS_INT_EN_FLAGS = 8'hd8;
  localparam logic [7:0] OFS_RESULT_LOW = 8'hd9;
  localparam logic [7:0] OFS_RESULT_MIDDLE = 8'hda;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'hdb;
  localparam logic [7:0] OFS_FRONT_CTRL = 8'hdc;
  localparam logic [7:0] OFS_MODE_CTRL = 8'hdd;

  // reset values
  localparam logic [7:0] RST_GAIN_CAL_MIDDLE = 8'hec;
  localparam logic [7:0] RST_GAIN_CAL_HIGH = 8'h5f;
  localparam logic [7:0] RST_INPUT_SELECT = 8'h01;
  localparam logic [7:0] RST_INT_EN_FLAGS = 8'h40;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_FRONT_CTRL = 8'h30;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;

  // interrupt enable and flag register fields
  localparam int BIT_BAUD_DOUBLE = 7;
  localparam int BIT_FIXED_ONE = 6;
  localparam int BIT_AUX_ENABLE = 5;
  localparam int BIT_AUX_FLAG = 4;
  localparam int BIT_WDT_FLAG = 3;
  localparam logic [7:0] INT_EN_FLAGS_RW_MASK = 8'hb8;
  localparam logic [7:0] INT_EN_FLAGS_FIXED = 8'h40;

  // analog front control fields
  localparam int BIT_BURNOUT = 6;
  localparam int BIT_VREF_EN = 5;
  localparam int BIT_VREF_HIGH = 4;
  localparam int BIT_BUFFER_EN = 3;
  localparam logic [7:0] FRONT_CTRL_RW_MASK = 8'h7f;

  // conversion mode control fields
  localparam int BIT_POLARITY = 6;
  localparam int POS_FILTER = 4;
  localparam logic [7:0] MODE_CTRL_RW_MASK = 8'h70;

  // input selector codes
  localparam logic [3:0] SEL_TEMP_SENSOR = 4'hf;
  localparam logic [7:0] SEL_TEMP_BOTH = 8'hff;

  // calibration command codes
  localparam logic [2:0] CAL_NONE = 3'h0;
  localparam logic [2:0] CAL_SYS_GAIN = 3'h5;
  localparam logic [2:0] CAL_READBACK = 3'h0;

  localparam int RESULT_W = 24;
  localparam int SAMPLE_W = 25;
endpackage

// [core/result_hold.sv]
// captures a converter sample and codes it as bipolar or unipolar result
`timescale 1ns/1ps
module result_hold (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sample_valid,
  input wire logic signed [adc_ctrl_pkg::SAMPLE_W-1:0] sample,
  input wire logic unipolar,
  output logic [adc_ctrl_pkg::RESULT_W-1:0] result_q,
  output logic result_new_q
);
  logic [adc_ctrl_pkg::RESULT_W-1:0] result_d;
  logic signed [adc_ctrl_pkg::SAMPLE_W-1:0] half_step;

  // sample is in unipolar steps, so bipolar halves it and never overflows
  always_comb begin
    half_step = sample >>> 1;
    if (unipolar) begin
      result_d = sample[adc_ctrl_pkg::SAMPLE_W-1] ? '0 : sample[adc_ctrl_pkg::RESULT_W-1:0]; // R16
    end else begin
      result_d = half_step[adc_ctrl_pkg::RESULT_W-1:0]; // R15 R16
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      result_q <= '0;
      result_new_q <= 1'b0;
    end else begin
      result_new_q <= sample_valid;
      if (sample_valid) begin
        result_q <= result_d;
      end
    end
  end

  a_unipolar_floor: assert property (@(posedge clk) disable iff (!nrst) // R16
    sample_valid && unipolar && sample[adc_ctrl_pkg::SAMPLE_W-1] |=> result_q == '0)
    else $error("unipolar negative sample not floored to zero");
endmodule

// [testbench/sfr_core_model.sv]
// bus-side model of the core issuing special function register accesses
`timescale 1ns/1ps
module sfr_core_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // released data must not look like the last write
    wdata <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule

// [testbench/adc_control_registers_tb_top.sv]
// self-checking bench for the converter control registers
`timescale 1ns/1ps
module adc_control_registers_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr, wdata, rdata, gcl = 8'h77, gfac;
  logic wr, rd, hit, aux = 1'b0, wdt = 1'b0, wen = 1'b0, wra = 1'b1, done = 1'b0;
  logic signed [24:0] smp = 25'h0;
  logic [23:0] gcal;
  logic [3:0] pos, neg;
  logic [2:0] gsel, ccmd;
  logic [1:0] sfm;
  logic temp, baud, auxreq, wdtreq, irq, burnout_detect, vren, vrh, bufen, coding_polarity, sse, cst;
  int num_errors = 0;
  int cmp_count = 0;
  always #10 clk = ~clk;
  adc_control_registers DUT (.CORE_CLK(clk), .NRST(nrst), .SFR_ADDR(addr), .SFR_WDATA(wdata),
    .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .SFR_HIT(hit), .GAIN_CAL_LOW(gcl), .GAIN_CAL(gcal),
    .POSITIVE_INPUT_FIELD(pos), .NEGATIVE_INPUT_FIELD(neg), .TEMP_SENSOR_SEL(temp),
    .SECOND_PORT_BAUD_DOUBLE(baud), .AUX_EVENT(aux), .AUX_INT_REQ(auxreq), .WDT_EVENT(wdt),
    .WDT_INT_EN(wen), .WDT_RESET_ACTION(wra), .WDT_INT_REQ(wdtreq), .CONV_DONE(done),
    .CONV_SAMPLE(smp), .CONV_IRQ(irq), .BURNOUT_DETECT(burnout_detect), .INTERNAL_REFERENCE_ENABLE(vren),
    .REFERENCE_LEVEL_SELECT(vrh), .INPUT_BUFFER_ENABLE(bufen), .GAIN_SELECT(gsel),
    .GAIN_FACTOR(gfac), .CODING_POLARITY(coding_polarity), .SUM_SIGN_EXTEND(sse),
    .SETTLING_FILTER_MODE(sfm), .CAL_START(cst), .CALIBRATION_COMMAND(ccmd));
  sfr_core_model CORE (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    CORE.rd_reg(a, d);
    chk(24'(d), 24'(e));
  endtask
  task automatic conclude;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic t_reset;
    logic [7:0] rv [9] = '{8'hec, 8'h5f, 8'h01, 8'h40, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00};
    for (int i = 0; i < 9; i++) rchk(8'hd5 + 8'(i), rv[i]);
    rchk(8'hde, 8'h00);
    chk(24'(hit), 24'h0);
    rchk(8'hdd, 8'h00);
    chk(24'(hit), 24'h1);
    chk(24'({burnout_detect, vren, vrh, bufen, baud, auxreq, gfac}), 24'h1801);
  endtask
  task automatic t_gain;
    CORE.wr_reg(8'hd5, 8'ha5);
    #1 chk(gcal, 24'h5fa577);
    CORE.wr_reg(8'hd6, 8'h3c);
    #1 chk(gcal, 24'h3ca577);
    rchk(8'hd5, 8'ha5);
    CORE.wr_reg(8'hd9, 8'h55);
    rchk(8'hd9, 8'h00);
  endtask
  task automatic t_mux;
    logic [3:0] c;
    for (int i = 0; i < 10; i++) begin
      c = i < 9 ? 4'(i) : 4'hf;
      CORE.wr_reg(8'hd7, {c, c});
      #1 chk(24'({pos, neg, temp}), 24'({c, c, c == 4'hf}));
    end
    CORE.wr_reg(8'hd7, 8'hf1);
    #1 chk(24'({pos, neg, temp}), 24'h1e2);
  endtask
  task automatic t_front;
    for (int g = 0; g < 8; g++) begin
      CORE.wr_reg(8'hdc, 8'hc8 | 8'(g));
      #1 chk(24'({burnout_detect, vren, vrh, bufen, gsel, gfac}), 24'({4'b1001, 3'(g), 8'h01 << g}));
      rchk(8'hdc, 8'h48 | 8'(g));
    end
    CORE.wr_reg(8'hdc, 8'h30);
  endtask
  task automatic t_mode;
    logic [2:0] cal, last;
    logic [1:0] f;
    logic p;
    last = 3'h0;
    for (int i = 0; i < 8; i++) begin
      cal = 3'(i);
      f = cal[1:0];
      p = cal[2];
      CORE.wr_reg(8'hdd, {1'b1, p, f, 1'b1, cal});
      if (cal >= 3'd1 && cal <= 3'd5) last = cal;
      #1 chk(24'({cst, ccmd, coding_polarity, sse, sfm}), 24'({cal >= 3'd1 && cal <= 3'd5, last, p, ~p, f}));
      rchk(8'hdd, {1'b0, p, f, 4'h0});
      chk(24'(cst), 24'h0);
    end
  endtask
  task automatic t_conv;
    logic [7:0] h, m, l;
    logic signed [24:0] s [4] = '{25'h0fffffe, 25'h1000000, 25'h0ffffff, 25'h1ffffff};
    logic [23:0] e [4] = '{24'h7fffff, 24'h800000, 24'hffffff, 24'h000000};
    for (int i = 0; i < 4; i++) begin
      CORE.wr_reg(8'hdd, i < 2 ? 8'h00 : 8'h40);
      @(posedge clk);
      done <= 1'b1;
      smp <= s[i];
      @(posedge clk);
      done <= 1'b0;
      smp <= ~s[i];
      @(posedge clk);
      #1 chk(24'(irq), 24'h1);
      CORE.rd_reg(8'hdb, h);
      CORE.rd_reg(8'hda, m);
      CORE.rd_reg(8'hd9, l);
      chk({h, m, l}, e[i]);
      chk(24'(irq), 24'h0);
    end
  endtask
  task automatic t_flags;
    CORE.wr_reg(8'hd8, 8'h20);
    @(posedge clk);
    aux <= 1'b1;
    @(posedge clk);
    aux <= 1'b0;
    #1 chk(24'(auxreq), 24'h1);
    CORE.wr_reg(8'hd8, 8'h20);
    #1 chk(24'(auxreq), 24'h0);
    CORE.wr_reg(8'hd8, 8'h10);
    #1 chk(24'(auxreq), 24'h0);
    CORE.wr_reg(8'hd8, 8'h30);
    #1 chk(24'(auxreq), 24'h1);
    // software clear and hardware event sampled on the same edge
    fork
      CORE.wr_reg(8'hd8, 8'h20);
      begin
        @(posedge clk);
        aux <= 1'b1;
        @(posedge clk);
        aux <= 1'b0;
      end
    join
    #1 chk(24'(auxreq), 24'h1);
    @(posedge clk);
    wen <= 1'b1;
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    #1 chk(24'(wdtreq), 24'h0);
    rchk(8'hd8, 8'h78);
    @(posedge clk);
    wra <= 1'b0;
    @(posedge clk);
    #1 chk(24'(wdtreq), 24'h1);
    CORE.wr_reg(8'hd8, 8'hff);
    #1 chk(24'(baud), 24'h1);
    rchk(8'hd8, 8'hf8);
    CORE.wr_reg(8'hd8, 8'h00);
    #1 chk(24'({baud, wdtreq, auxreq}), 24'h0);
    rchk(8'hd8, 8'h40);
  endtask

  initial begin
    // whole run needs well under two thousand cycles
    #200us;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_gain();
    t_mux();
    t_front();
    t_mode();
    t_conv();
    t_flags();
    conclude();
  end
endmodule
